// file: bbc_duty_meas.sv
// Measures the high-time fraction of the pwm input over a fixed window.
// Assumes the input is already synchronous to clk.
`default_nettype none
module bbc_duty_meas #(
  parameter int WIN_LOG2 = 18
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pwm_in,
  output logic [9:0] duty_q,
  output logic active_q
);
  logic [WIN_LOG2-1:0] win_q;
  logic [WIN_LOG2:0] hi_q;
  logic [WIN_LOG2:0] hi_tot;
  logic prev_q;
  logic edge_q;

  assign hi_tot = hi_q + {{WIN_LOG2{1'b0}}, pwm_in};

  ////////////////////////////////////////////////////////////////////////////
  // Window counting; window longer than the slowest legal input period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_q <= '0;
      hi_q <= '0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
      duty_q <= 10'h000;
      active_q <= 1'b0;
    end else begin
      prev_q <= pwm_in;
      win_q <= win_q + WIN_LOG2'(1);
      if (&win_q) begin
        // Full-high window would read 1024, so saturate
        duty_q <= hi_tot[WIN_LOG2] ? 10'h3ff : hi_tot[WIN_LOG2-1 -: 10];
        active_q <= edge_q || (prev_q != pwm_in);
        hi_q <= '0;
        edge_q <= 1'b0;
      end else begin
        hi_q <= hi_tot;
        edge_q <= edge_q || (prev_q != pwm_in);
      end
    end
  end
endmodule
`default_nettype wire

// file: bbc_pkg.sv
// Shared constants, types and register map of the backlight brightness control.
// Assumes a single 25 MHz clock and a classic Wishbone register bus.
`default_nettype none
package bbc_pkg;
  localparam int CLK_HZ = 25_000_000;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BR_MAIN = 8'h04;
  localparam logic [7:0] A_BR_SUB = 8'h08;
  localparam logic [7:0] A_CUR_MAIN = 8'h0c;
  localparam logic [7:0] A_CUR_SUB = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_NVM_CMD = 8'h18;
  localparam logic [7:0] A_DUTY = 8'h1c;
  localparam logic [1:0] A_SHADOW_HI = 2'h1; // Shadow RAM at 0x40..0x7c

  // Control register fields and reset value
  localparam int CTRL_SEL = 0; // Pwm input selected
  localparam int CTRL_MD = 1; // pwm_direct_mode_bit
  localparam int CTRL_PS = 2; // phase_staggered_dimming enable
  localparam int CTRL_ALS = 3; // Ambient compensation enable
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [7:0] BR_RST = 8'hff;

  // Status register fields
  localparam int ST_OPEN = 0;
  localparam int ST_SHORT = 7;
  localparam int ST_OFF = 16;
  localparam int ST_HOT = 17;
  localparam int ST_BUSY = 18;

  // Non-volatile map (byte index)
  localparam int N_CUR_MAIN = 0;
  localparam int N_CUR_SUB = 1;
  localparam int N_X1 = 2;
  localparam int N_X2 = 3;
  localparam int N_S0 = 4;
  localparam int N_S1 = 5;
  localparam int N_S2 = 6;
  localparam int N_FREQ = 7;
  localparam int N_CONF = 8; // [1:0] string count code, [2] sensor enable level
  localparam int N_OPEN = 9;
  localparam int N_SHORT = 10;
  localparam int N_TEMP = 11;
  localparam int N_PRESC = 12;
  localparam int N_ALS_BASE = 13;
  localparam int N_ALS_SLOPE = 14;
  localparam int NVM_WORDS = 16;

  // Current code scale
  localparam int CUR_STEP_UA = 230;
  localparam int CUR_MAX_UA = 60_000;
  localparam int CUR_FACTORY_UA = 20_000;
  localparam logic [7:0] CUR_FACTORY = 8'(CUR_FACTORY_UA / CUR_STEP_UA);
  localparam logic [NVM_WORDS-1:0][7:0] NVM_FACTORY = {8'h00, 8'h10, 8'h80, 8'h00,
    8'hc8, 8'hf0, 8'h08, 8'h02, 8'h06, 8'h18, 8'h10, 8'h08, 8'hc0, 8'h40,
    CUR_FACTORY, CUR_FACTORY};

  // Output pwm timing
  localparam int PWM_STEPS = 1024;
  localparam int PWM_F_MIN_HZ = 229;
  localparam int PWM_F_MAX_HZ = 19_500;
  localparam logic [7:0] DIV_MIN = 8'((CLK_HZ + PWM_STEPS * PWM_F_MAX_HZ - 1)
                                      / (PWM_STEPS * PWM_F_MAX_HZ));
  localparam logic [7:0] DIV_MAX = 8'(CLK_HZ / (PWM_STEPS * PWM_F_MIN_HZ));

  // Input pwm timing
  localparam int PWM_IN_F_MIN_HZ = 100;
  localparam int MEAS_WIN_LOG2 = 18; // 2^18 cycles covers one slowest period
  localparam int T_OFF_MS = 50;
  localparam int T_OFF_CYC = CLK_HZ / 1000 * T_OFF_MS;

  // Ambient sensor, thermal and programming timing
  localparam int ALS_WIN_UNIT = 4096;
  localparam logic [7:0] THERM_SCALE = 8'h80;
  localparam int T_NVM_WR_US = 100;
  localparam int NVM_WR_CYC = CLK_HZ / 1_000_000 * T_NVM_WR_US;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_LOAD = 2'b01,
    NV_PROG = 2'b10
  } bbc_nvm_st_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bbc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } bbc_wb_rsp_t;
endpackage
`default_nettype wire

// file: bbc_pwm_host.sv
// Host pwm source for the brightness control input.
// Assumes the design clock; period and high time in clock cycles.
`default_nettype none
module bbc_pwm_host #(
  parameter int PERIOD = 1024,
  parameter int HIGH = 256
) (
  input wire logic clk,
  input wire logic en,
  output logic pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  // input rate in band
  // A period of 1000 to 250000 cycles keeps the host within its rate band
  always @(posedge clk) begin
    cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    pwm <= en && (cnt_q < HIGH);
  end
endmodule
`default_nettype wire

// file: bbc_top.sv
// Backlight brightness control: current codes, pwm curve, input duty, phase
// staggering, thermal, ambient sensor, faults and non-volatile programming.
// Assumes one 25 MHz clock, synchronous inputs and a classic Wishbone master.
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
// How it works
// - Load current codes from nonvolatile at activation
// - Host current write replaces nonvolatile default
// - Code steps 0.23 mA, zero to 60 mA
// - Separate current and brightness per group
// - Brightness register drives pwm duty
// - Piecewise-linear curve from nonvolatile coefficients
// - Output pwm from 229 Hz to 19.5 kHz
// - Measure input high fraction for duty
// - Combined mode scales main group register brightness by duty
// - Pwm-only mode, input low means shutdown
// - Input activity returns, power up with duty
// - Staggered dimming offsets string on-times
// - Stagger pattern follows string count four to seven
// - Strings up to the count main, string seven sub group unless all seven main
// - Open and short detect against nonvolatile thresholds
// - Fault sets status and pulls fault low
// - Above temperature threshold reduce duty
// - Sensor frequency becomes brightness correction
// - Sensor enable level from nonvolatile bit
// - Ambient correction only for main group
// - Shadow write then command copies to nonvolatile
// - Shutdown after 50 ms continuous low
// - Reset selects input duty measurement
module bbc_top #(
  parameter int OFF_CYC = bbc_pkg::T_OFF_CYC,
  parameter int WIN_LOG2 = bbc_pkg::MEAS_WIN_LOG2,
  parameter int WR_CYC = bbc_pkg::NVM_WR_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bbc_pkg::bbc_wb_req_t wb_req,
  output bbc_pkg::bbc_wb_rsp_t wb_rsp,
  input wire logic pwm_in,
  input wire logic light_sensor_freq_input,
  input wire logic [6:0][7:0] string_mon,
  input wire logic [7:0] temp_code,
  output logic [6:0] led_drv,
  output logic [7:0] cur_main,
  output logic [7:0] cur_sub,
  output logic sensor_en,
  output logic shutdown,
  output logic fault_out,
  output logic fault_oe_n
);
  import bbc_pkg::*;

  logic [7:0] nvm_q [NVM_WORDS];
  logic [7:0] shadow_q [NVM_WORDS];
  logic [3:0] ctrl_q;
  logic [7:0] br_main_q, br_sub_q;
  logic [6:0] open_q, short_q;
  logic hot_q, ack_q;
  logic [31:0] rdat_q;
  bbc_nvm_st_t nv_st_q;
  logic [3:0] nv_idx_q;
  logic [12:0] nv_cnt_q;
  logic wr, rd_go, cmd_go;
  logic [9:0] ext_duty;
  logic ext_active;
  logic [20:0] low_q;
  logic [6:0] led_q;
  logic [7:0] div_q, div_lim;
  logic [9:0] pcnt_q;
  logic [15:0] als_cnt_q;
  logic [19:0] als_win_q;
  logic [7:0] als_gain_q;
  logic als_prev_q;
  logic [9:0] duty_main, duty_sub, curve_out;
  logic [9:0] step;
  logic standalone, direct;

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdat_q;
  assign wr = wb_req.cyc && wb_req.stb && wb_req.we && !ack_q;
  assign rd_go = wb_req.cyc && wb_req.stb && !ack_q;
  assign cmd_go = wr && (wb_req.adr == A_NVM_CMD) && wb_req.sel[0] && wb_req.dat[0];
  assign direct = ctrl_q[CTRL_MD] && ctrl_q[CTRL_SEL];
  assign standalone = !ctrl_q[CTRL_MD] && ctrl_q[CTRL_SEL];
  assign led_drv = led_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= rd_go;
      rdat_q <= 32'h0000_0000; // Unmapped offsets read zero
      if (wb_req.adr[7:6] == A_SHADOW_HI) begin
        rdat_q <= {24'h0, shadow_q[wb_req.adr[5:2]]};
      end else begin
        case (wb_req.adr)
          A_CTRL: rdat_q <= {28'h0, ctrl_q};
          A_BR_MAIN: rdat_q <= {24'h0, br_main_q};
          A_BR_SUB: rdat_q <= {24'h0, br_sub_q};
          A_CUR_MAIN: rdat_q <= {24'h0, cur_main};
          A_CUR_SUB: rdat_q <= {24'h0, cur_sub};
          A_STATUS: rdat_q <= {13'h0, nv_st_q != NV_IDLE, hot_q, shutdown,
                               2'h0, short_q, open_q};
          A_DUTY: rdat_q <= {6'h0, duty_main, 6'h0, ext_duty};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and brightness registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      br_main_q <= BR_RST;
      br_sub_q <= BR_RST;
    end else if (wr && wb_req.sel[0]) begin
      case (wb_req.adr)
        A_CTRL: ctrl_q <= wb_req.dat[3:0];
        A_BR_MAIN: br_main_q <= wb_req.dat[7:0];
        A_BR_SUB: br_sub_q <= wb_req.dat[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current codes; one code step is CUR_STEP_UA, full scale CUR_MAX_UA
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur_main <= 8'h00;
      cur_sub <= 8'h00;
    end else if (nv_st_q == NV_LOAD) begin
      cur_main <= nvm_q[N_CUR_MAIN];
      cur_sub <= nvm_q[N_CUR_SUB];
    end else if (wr && wb_req.sel[0]) begin
      if (wb_req.adr == A_CUR_MAIN) begin
        cur_main <= wb_req.dat[7:0];
      end
      if (wb_req.adr == A_CUR_SUB) begin
        cur_sub <= wb_req.dat[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow RAM: loaded at activation, written by the host
  always_ff @(posedge clk) begin
    if (nv_st_q == NV_LOAD) begin
      for (int k = 0; k < NVM_WORDS; k++) begin
        shadow_q[k] <= nvm_q[k];
      end
    end else if (wr && wb_req.sel[0] && wb_req.adr[7:6] == A_SHADOW_HI) begin
      shadow_q[wb_req.adr[5:2]] <= wb_req.dat[7:0];
    end
  end

  // Memory array; the reset stands for first power-up with factory contents
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int k = 0; k < NVM_WORDS; k++) begin
        nvm_q[k] <= NVM_FACTORY[k];
      end
    end else if (nv_st_q == NV_PROG && nv_cnt_q == 13'(WR_CYC - 1)) begin
      nvm_q[nv_idx_q] <= shadow_q[nv_idx_q];
    end
  end

  // Programming sequencer: one word per write time, commands while busy ignored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nv_st_q <= NV_LOAD;
      nv_idx_q <= 4'h0;
      nv_cnt_q <= 13'h0000;
    end else begin
      case (nv_st_q)
        NV_LOAD: nv_st_q <= NV_IDLE;
        NV_IDLE: begin
          nv_idx_q <= 4'h0;
          nv_cnt_q <= 13'h0000;
          if (cmd_go) begin
            nv_st_q <= NV_PROG;
          end
        end
        NV_PROG: begin
          if (nv_cnt_q == 13'(WR_CYC - 1)) begin
            nv_cnt_q <= 13'h0000;
            nv_idx_q <= nv_idx_q + 4'h1;
            if (&nv_idx_q) begin
              nv_st_q <= NV_IDLE;
            end
          end else begin
            nv_cnt_q <= nv_cnt_q + 13'h0001;
          end
        end
        default: nv_st_q <= NV_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input duty measurement
  // high fraction measured
  bbc_duty_meas #(
    .WIN_LOG2(WIN_LOG2)
  ) u_meas (
    .clk(clk),
    .resetn(resetn),
    .pwm_in(pwm_in),
    .duty_q(ext_duty),
    .active_q(ext_active)
  );

  // Stand-alone off timer; no slope, so the plain low time decides
  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_q <= 21'h0;
      shutdown <= 1'b0;
    end else if (!standalone || pwm_in) begin
      low_q <= 21'h0;
      shutdown <= 1'b0;
    end else if (low_q == 21'(OFF_CYC - 1)) begin
      shutdown <= 1'b1;
    end else begin
      low_q <= low_q + 21'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ambient sensor: edges counted over a prescaled window
  always_ff @(posedge clk) begin
    if (!resetn) begin
      als_prev_q <= 1'b0;
      als_cnt_q <= 16'h0000;
      als_win_q <= 20'h00000;
      als_gain_q <= 8'hff;
    end else begin
      als_prev_q <= light_sensor_freq_input;
      if (als_win_q == 20'(({12'h0, nvm_q[N_PRESC]} + 20'h1) * 20'(ALS_WIN_UNIT) - 1)) begin
        als_win_q <= 20'h00000;
        als_cnt_q <= 16'h0000;
        als_gain_q <= 8'(({8'h0, nvm_q[N_ALS_BASE]} + ((als_cnt_q[7:0] * 16'(nvm_q[N_ALS_SLOPE]))
                      >> 4)) > 16'h00ff ? 16'h00ff
                      : {8'h0, nvm_q[N_ALS_BASE]} + ((als_cnt_q[7:0]
                      * 16'(nvm_q[N_ALS_SLOPE])) >> 4));
      end else begin
        als_win_q <= als_win_q + 20'h1;
        if (light_sensor_freq_input && !als_prev_q && !(&als_cnt_q)) begin
          als_cnt_q <= als_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Sensor enable level chosen by a configuration bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sensor_en <= 1'b0;
    end else begin
      sensor_en <= ctrl_q[CTRL_ALS] ? nvm_q[N_CONF][2] : !nvm_q[N_CONF][2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brightness curve: three segments, slopes in quarter steps
  function automatic logic [9:0] curve(input logic [7:0] x, input logic [7:0] x1,
                                       input logic [7:0] x2, input logic [7:0] s0,
                                       input logic [7:0] s1, input logic [7:0] s2);
    logic [17:0] y1;
    logic [17:0] y2;
    logic [17:0] y;
    y1 = ({10'h0, s0} * {10'h0, x1}) >> 2;
    y2 = y1 + (({10'h0, s1} * {10'h0, 8'(x2 - x1)}) >> 2);
    if (x < x1) begin
      y = ({10'h0, s0} * {10'h0, x}) >> 2;
    end else if (x < x2) begin
      y = y1 + (({10'h0, s1} * {10'h0, 8'(x - x1)}) >> 2);
    end else begin
      y = y2 + (({10'h0, s2} * {10'h0, 8'(x - x2)}) >> 2);
    end
    curve = (y > 18'd1023) ? 10'h3ff : y[9:0];
  endfunction

  assign curve_out = curve(br_main_q, nvm_q[N_X1], nvm_q[N_X2], nvm_q[N_S0],
                           nvm_q[N_S1], nvm_q[N_S2]);

  // Duty combination, all main group factors multiplied in one chain, sub group by the thermal scale only
  always_comb begin
    logic [9:0] base;
    logic [17:0] pa;
    logic [19:0] pe;
    logic [17:0] pt;
    logic [17:0] ps;
    base = ctrl_q[CTRL_SEL] ? ext_duty : curve_out;
    pa = {8'h0, base} * {10'h0, ctrl_q[CTRL_ALS] ? als_gain_q : 8'hff};
    pe = {10'h0, pa[17:8]} * {10'h0, ext_duty};
    if (ctrl_q[CTRL_SEL] || ctrl_q[CTRL_MD]) begin
      pe = {pa[17:8], 10'h0};
    end
    pt = {8'h0, pe[19:10]} * {10'h0, hot_q ? THERM_SCALE : 8'hff};
    duty_main = pt[17:8];
    ps = {8'h0, br_sub_q, br_sub_q[7:6]} * {10'h0, hot_q ? THERM_SCALE : 8'hff};
    duty_sub = ps[17:8];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hot_q <= 1'b0;
    end else begin
      hot_q <= temp_code > nvm_q[N_TEMP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pwm period: divider clamped to the legal frequency span
  // frequency limits
  assign div_lim = (nvm_q[N_FREQ] < DIV_MIN) ? DIV_MIN
                 : (nvm_q[N_FREQ] > DIV_MAX) ? DIV_MAX : nvm_q[N_FREQ];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= 8'h00;
      pcnt_q <= 10'h000;
    end else if (div_q >= div_lim - 8'h01) begin
      div_q <= 8'h00;
      pcnt_q <= pcnt_q + 10'h001;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Phase step per string count (4..7 strings)
  // pattern follows count
  always_comb begin
    case (nvm_q[N_CONF][1:0])
      2'h0: step = 10'd256;
      2'h1: step = 10'd205;
      2'h2: step = 10'd171;
      default: step = 10'd146;
    endcase
  end

  // String drivers; string seven is sub group unless all seven are main
  for (genvar i = 0; i < 7; i++) begin : g_str
    logic [9:0] ph;
    logic [9:0] rel;
    logic main_en;
    logic lit;
    assign ph = ctrl_q[CTRL_PS] ? 10'({3'h0, step} * 13'(i)) : 10'h000;
    assign rel = pcnt_q - ph;
    assign main_en = (3'(i) <= {1'b0, nvm_q[N_CONF][1:0]} + 3'h3);
    assign lit = main_en ? (direct ? pwm_in : rel < duty_main)
               : (i == 6) && (pcnt_q < duty_sub);

    always_ff @(posedge clk) begin
      if (!resetn) begin
        led_q[i] <= 1'b0;
      end else begin
        led_q[i] <= lit && !shutdown;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      open_q <= 7'h00;
      short_q <= 7'h00;
    end else begin
      for (int k = 0; k < 7; k++) begin
        open_q[k] <= (open_q[k] && !(wr && wb_req.adr == A_STATUS && wb_req.sel[0]
                      && wb_req.dat[ST_OPEN + k]))
                     || (led_q[k] && string_mon[k] < nvm_q[N_OPEN]);
        short_q[k] <= (short_q[k] && !(wr && wb_req.adr == A_STATUS
                       && wb_req.sel[(ST_SHORT + k) / 8] && wb_req.dat[ST_SHORT + k]))
                      || (led_q[k] && string_mon[k] > nvm_q[N_SHORT]);
      end
    end
  end

  // Open-drain fault pin: data always low, enable low while pulling
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fault_out <= 1'b0;
      fault_oe_n <= 1'b1;
    end else begin
      fault_out <= 1'b0;
      fault_oe_n <= !(|open_q || |short_q);
    end
  end
endmodule
`default_nettype wire

// file: bbc_top_asserts.sv
// Port-level checks of the brightness control top.
// Assumes it is bound onto bbc_top with OFF_CYC handed on.
`default_nettype none
module bbc_top_asserts #(
  parameter int OFF_CYC = 200
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bbc_pkg::bbc_wb_req_t wb_req,
  input wire bbc_pkg::bbc_wb_rsp_t wb_rsp,
  input wire logic pwm_in,
  input wire logic [6:0] led_drv,
  input wire logic shutdown,
  input wire logic fault_out,
  input wire logic fault_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import bbc_pkg::*;
  logic [20:0] low_q;
  logic st_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Low run length, saturating so a long idle never wraps to zero
  always_ff @(posedge clk) begin
    if (!resetn || pwm_in) begin
      low_q <= '0;
    end else if (low_q != '1) begin
      low_q <= low_q + 21'h1;
    end
  end
  // Status write taken at this edge
  assign st_wr = wb_req.cyc && wb_req.stb && !wb_rsp.ack && wb_req.we
    && (wb_req.adr == A_STATUS);
  ////////////////////////////////////////
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_dark;
    shutdown ##1 shutdown;
  endsequence
  property p_ack_resp; s_req |=> wb_rsp.ack; endproperty
  property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  property p_no_spur; !(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack; endproperty
  property p_od_low; fault_out == 1'b0; endproperty
  property p_fault_hold; !fault_oe_n && !st_wr && !$past(st_wr) |=> !fault_oe_n; endproperty
  property p_off_delay; $rose(shutdown) |-> low_q >= OFF_CYC - 1; endproperty
  property p_wake; shutdown && pwm_in |=> !shutdown; endproperty
  property p_dark; s_dark |-> led_drv == 7'h00; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_no_spur: assert property (p_no_spur) else $error("ack without request");
  a_od_low: assert property (p_od_low) else $error("fault pin data not low");
  a_fault_hold: assert property (p_fault_hold) else $error("fault released early");
  a_off_delay: assert property (p_off_delay) else $error("shutdown too early");
  a_wake: assert property (p_wake) else $error("no wake on input high");
  a_dark: assert property (p_dark) else $error("strings lit in shutdown");
endmodule
bind bbc_top bbc_top_asserts #(.OFF_CYC(OFF_CYC)) u_asserts (.clk(clk), .resetn(resetn),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .pwm_in(pwm_in), .led_drv(led_drv),
  .shutdown(shutdown), .fault_out(fault_out), .fault_oe_n(fault_oe_n));
`default_nettype wire

// file: tb_bbc_top.sv
// Self-checking bench of the brightness control top over Wishbone.
// Assumes the host pwm model and the bound checker.
`default_nettype none
module tb_bbc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bbc_pkg::*;
  localparam int OFF = 2000; // Longer than the host's longest low phase
  localparam int WIN = 10;
  localparam int WRC = 4;
  localparam int PER = 1024;
  localparam int HI = 256;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pwm_en = 1'b1;
  logic pwm_in;
  logic [6:0][7:0] string_mon = {7{8'h80}};
  logic [7:0] temp_code = 8'h10;
  bbc_wb_req_t wb_req = '0;
  bbc_wb_rsp_t wb_rsp;
  logic [6:0] led_drv;
  logic [7:0] cur_main;
  logic [7:0] cur_sub;
  logic sensor_en;
  logic shutdown;
  logic fault_out;
  logic fault_oe_n;
  logic [31:0] rd;
  logic [9:0] duty_ref;
  logic als_run = 1'b0;
  logic als_in = 1'b0;
  logic [5:0] als_div = 6'h00;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  bbc_top #(.OFF_CYC(OFF), .WIN_LOG2(WIN), .WR_CYC(WRC)) u_dut (.clk(clk), .resetn(resetn),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .pwm_in(pwm_in), .light_sensor_freq_input(als_in),
    .string_mon(string_mon), .temp_code(temp_code), .led_drv(led_drv),
    .cur_main(cur_main), .cur_sub(cur_sub), .sensor_en(sensor_en), .shutdown(shutdown),
    .fault_out(fault_out), .fault_oe_n(fault_oe_n));
  bbc_pwm_host #(.PERIOD(PER), .HIGH(HI)) u_host (.clk(clk), .en(pwm_en), .pwm(pwm_in));
  // Light sensor stand-in: one rising edge every 64 cycles while running
  always @(posedge clk) begin
    als_div <= als_div + 6'h01;
    als_in <= als_run && als_div[5];
  end
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do @(posedge clk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(n, exp, rd & m);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("cur_main_rst", 32'(CUR_FACTORY), 32'(cur_main));
    chk("cur_sub_rst", 32'(CUR_FACTORY), 32'(cur_sub));
    chk("sens_idle", 32'(!NVM_FACTORY[N_CONF][2]), 32'(sensor_en));
    rchk("ctrl", A_CTRL, '1, 32'(CTRL_RST));
    rchk("br_main", A_BR_MAIN, '1, 32'(BR_RST));
    rchk("br_sub", A_BR_SUB, '1, 32'(BR_RST));
    // Per-group override, unmapped place ignored
    wb(1'b1, A_CUR_MAIN, 32'h12);
    wb(1'b1, A_CUR_SUB, 32'h34);
    wb(1'b1, 8'ha0, 32'h5a);
    rchk("unmapped", 8'ha0, '1, 32'h0);
    rchk("cur_sub_reg", A_CUR_SUB, '1, 32'h34);
    chk("cur_main", 32'h12, 32'(cur_main));
    chk("cur_sub", 32'h34, 32'(cur_sub));
    repeat (3 << WIN) @(posedge clk);
    rchk("duty_in", A_DUTY, 32'h3ff, 32'(HI * (1 << WIN) / PER));
    // Input held low in the default mode, counted from its last high
    while (pwm_in !== 1'b1) @(posedge clk);
    pwm_en <= 1'b0;
    repeat (OFF - 20) @(posedge clk);
    chk("early_off", 32'h0, 32'(shutdown));
    repeat (40) @(posedge clk);
    chk("off", 32'h1, 32'(shutdown));
    rchk("st_off", A_STATUS, 32'h1 << ST_OFF, 32'h1 << ST_OFF);
    pwm_en <= 1'b1;
    repeat (PER) @(posedge clk);
    chk("wake", 32'h0, 32'(shutdown));
    // Temperature at and above the threshold, register brightness mode
    wb(1'b1, A_CTRL, 32'h2);
    temp_code <= 8'hc8;
    rchk("cool", A_STATUS, 32'h1 << ST_HOT, 32'h0);
    wb(1'b0, A_DUTY, 32'h0);
    duty_ref = rd[25:16];
    temp_code <= 8'hc9;
    repeat (8) @(posedge clk);
    rchk("hot", A_STATUS, 32'h1 << ST_HOT, 32'h1 << ST_HOT);
    wb(1'b0, A_DUTY, 32'h0);
    chk("therm_cut", 32'h1, 32'(rd[25:16] < duty_ref));
    temp_code <= 8'h10;
    // Combined mode: the input duty only scales the register value down
    wb(1'b1, A_CTRL, 32'h0);
    wb(1'b0, A_DUTY, 32'h0);
    chk("comb_scale", 32'h1, 32'(rd[25:16] < duty_ref));
    // Ambient gain: light edges raise the main group duty
    wb(1'b1, A_CTRL, 32'ha);
    @(posedge clk);
    chk("sens_on", 32'(NVM_FACTORY[N_CONF][2]), 32'(sensor_en));
    repeat (2 * ALS_WIN_UNIT) @(posedge clk);
    wb(1'b0, A_DUTY, 32'h0);
    duty_ref = rd[25:16];
    als_run <= 1'b1;
    repeat (2 * ALS_WIN_UNIT) @(posedge clk);
    wb(1'b0, A_DUTY, 32'h0);
    chk("als_gain", 32'h1, 32'(rd[25:16] > duty_ref));
    als_run <= 1'b0;
    // Faults beside the thresholds, register brightness mode
    wb(1'b1, A_CTRL, 32'h2);
    string_mon <= {8'h80, 8'h80, 8'h80, 8'hf0, 8'h08, 8'hf1, 8'h07};
    repeat (13000) if (fault_oe_n !== 1'b0) @(posedge clk);
    rchk("st_flt", A_STATUS, 32'h3fff, 32'h101);
    chk("fault_pull", 32'h0, 32'(fault_oe_n));
    string_mon <= {7{8'h80}};
    wb(1'b1, A_STATUS, 32'h1);
    rchk("st_clr1", A_STATUS, 32'h3fff, 32'h100);
    chk("fault_held", 32'h0, 32'(fault_oe_n));
    wb(1'b1, A_STATUS, 32'h100);
    repeat (2) @(posedge clk);
    chk("fault_rel", 32'h1, 32'(fault_oe_n));
    // Shadow writes, then program command; a low temperature limit shows the copy
    wb(1'b1, 8'h40, 32'h2a);
    wb(1'b1, 8'h6c, 32'h08);
    rchk("shadow", 8'h40, '1, 32'h2a);
    wb(1'b1, A_NVM_CMD, 32'h1);
    rchk("busy", A_STATUS, 32'h1 << ST_BUSY, 32'h1 << ST_BUSY);
    repeat (16 * WRC + 8) @(posedge clk);
    rchk("idle", A_STATUS, 32'h1 << ST_BUSY, 32'h0);
    rchk("nvm_temp", A_STATUS, 32'h1 << ST_HOT, 32'h1 << ST_HOT);
    summarize();
  end
endmodule
`default_nettype wire
